// File: src/ifw_node.sv
// Interlock node: dataway registers, fault latch, permission outputs, watchdog
//
// Function
// R01 - The loopback register returns exactly what was last written to it.
// R02 - A write to subaddress 1 sets every mask output to the written bit level.
// R03 - Mask bits 1 to 15 drive a primary and a backup output, bit 0 only one.
// R04 - A read at subaddress 0 returns faults, watchdog on top, shared line at bottom.
// R05 - With no masks and no permissions, a reset leaves every input fault bit set.
// R06 - Any access, even the status read, clears the watchdog condition.
// R07 - The shared line fault bit is set only when that line is grounded outside.
// R08 - With all inputs masked, two reset commands leave the fault register clear.
// R09 - The switch value picks a timeout doubling from 6.55 ms up to 214.7 s.
// R10 - The watchdog counts on the node's own 5 MHz permission tick.
// R11 - Every dataway command of any function zeroes the watchdog count.
// R12 - A watchdog timeout removes permission and flags the fault register.
// R13 - A removed permission stays latched until a reset command arrives.
// R14 - The timeout is 32768 ticks times two to the switch value.
`timescale 1ns/100ps
`default_nettype none
`include "ifw_map.svh"

module ifw_node
    import ifw_pkg::*;
#(
    parameter int unsigned WD_BASE_TICKS = `IFW_WD_BASE_TICKS
) (
    input  wire logic             clk,                   // System clock, 125 MHz
    input  wire logic             sys_rst,               // Synchronous reset
    input  wire ifw_pkg::ifw_cmd_t cmd,                  // Dataway command
    output ifw_pkg::ifw_rsp_t     rsp,                   // Dataway answer
    input  wire logic [14:1]      chan_permit,           // Input has permission
    input  wire logic [3:0]       timeout_sel,           // Watchdog switch value
    input  wire logic             shared_line_i,         // Backplane line level
    output logic                  shared_line_o,         // Backplane line drive value
    output logic                  shared_line_oe,        // Backplane line pulled low
    output logic                  shutdown_interlock,    // Permission pulse train
    output logic                  auxiliary_permit_output, // Local permission copy
    output logic                  timer_trip_output,     // Watchdog tripped
    output logic [15:0]           mask_pri,              // Mask outputs, primary
    output logic [15:1]           mask_bak               // Mask outputs, backup
);

    import ifw_pkg::*;

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    ifw_state_t    state_reg;
    ifw_state_t    state_next;
    logic [15:0]   fault_reg;
    logic [15:0]   fault_next;
    logic [15:0]   mask_reg;
    logic [15:0]   mask_next;
    logic [15:0]   loop_reg;
    logic [15:0]   loop_next;
    ifw_rsp_t      rsp_reg;
    ifw_rsp_t      rsp_next;
    logic [4:0]    div_reg;
    logic [4:0]    div_next;
    logic          phase_reg;
    logic          phase_next;
    logic          perm_reg;
    logic          perm_next;
    logic          aux_reg;
    logic          aux_next;
    logic          trip_out_reg;
    logic          trip_out_next;
    logic          line_oe_reg;
    logic          line_oe_next;
    logic          line_o_reg;
    logic [15:0]   mask_pri_reg;
    logic [15:0]   mask_pri_next;
    logic [15:1]   mask_bak_reg;
    logic [15:1]   mask_bak_next;
    logic          tick;
    logic          wd_trip;
    logic          access;
    logic          line_fault;
    logic [14:0]   chan_fault;
    logic          raw_fault;
    logic [15:0]   snapshot;
    logic          do_read;
    logic          do_wmask;
    logic          do_wloop;
    logic          do_nop;
    logic          do_reset;
    logic          known;

    // Matches one function code and subaddress of the current command
    function automatic logic is_cmd(
        input ifw_cmd_t   c,
        input logic [4:0] f,
        input logic [3:0] a
    );
        is_cmd = c.valid && (c.func == f) && (c.sub == a);
    endfunction : is_cmd

    // ------------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------------
    always_comb
    begin
        access   = cmd.valid; // R06 R11
        do_read  = is_cmd(cmd, `IFW_FN_READ, `IFW_SA_FAULT)
                 | is_cmd(cmd, `IFW_FN_READ, `IFW_SA_MASK)
                 | is_cmd(cmd, `IFW_FN_READ, `IFW_SA_LOOP);
        do_nop   = is_cmd(cmd, `IFW_FN_WRITE, `IFW_SA_NOP);
        do_wmask = is_cmd(cmd, `IFW_FN_WRITE, `IFW_SA_MASK);
        do_wloop = is_cmd(cmd, `IFW_FN_WRITE, `IFW_SA_LOOP);
        do_reset = is_cmd(cmd, `IFW_FN_RESET, `IFW_SA_FAULT);
        known    = do_read | do_nop | do_wmask | do_wloop | do_reset;
    end

    // ------------------------------------------------------------------------
    // Permission tick, 5 MHz square wave from the system clock
    // ------------------------------------------------------------------------
    always_comb
    begin
        tick     = (div_reg == 5'(`IFW_DIV_CYCLES - 1));
        div_next = tick ? 5'h00 : div_reg + 5'h01;
        // Odd divide ratio gives a 12/13 split, well inside 40-60 percent duty
        phase_next = (div_next < 5'(`IFW_DIV_HALF));
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_reg   <= 5'h00;
            phase_reg <= 1'b0;
        end
        else
        begin
            div_reg   <= div_next;
            phase_reg <= phase_next;
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------------
    ifw_watchdog #(
        .BASE_TICKS (WD_BASE_TICKS)
    ) u_watchdog (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (tick),        // R10
        .clear   (access),      // R06 R11
        .sel     (timeout_sel), // R09
        .trip    (wd_trip)
    );

    // ------------------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------------------
    always_comb
    begin
        // Own low drive is excluded, so only an outside short counts
        line_fault = ~shared_line_i & ~line_oe_reg; // R07
        chan_fault = {~chan_permit, line_fault} & ~mask_reg[`IFW_CHAN_MSB:0];
        raw_fault  = (|chan_fault) | wd_trip; // R12
        snapshot   = {wd_trip, chan_fault}; // R04
    end

    // ------------------------------------------------------------------------
    // Fault latch and fault register
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        fault_next = fault_reg;
        case (state_reg)
            IFW_PERMIT:
            begin
                if (raw_fault)
                begin
                    state_next = IFW_TRIPPED; // R12
                    fault_next = snapshot; // R05 R07
                end
                else if (do_reset)
                begin
                    fault_next = `IFW_FAULT_RST; // R08
                end
            end
            IFW_TRIPPED:
            begin
                // Release only; a fault still present relatches and restrobes
                if (do_reset)
                    state_next = IFW_PERMIT; // R13 R05 R08
            end
            default:
            begin
                state_next = IFW_TRIPPED;
            end
        endcase
        // Access clears the watchdog flag; a fresh capture of a trip wins
        if (access && !(state_reg == IFW_PERMIT && raw_fault && wd_trip))
            fault_next[`IFW_WD_BIT] = 1'b0; // R06
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_reg <= IFW_PERMIT;
            fault_reg <= `IFW_FAULT_RST;
        end
        else
        begin
            state_reg <= state_next;
            fault_reg <= fault_next;
        end
    end

    // ------------------------------------------------------------------------
    // Mask and loopback registers
    // ------------------------------------------------------------------------
    always_comb
    begin
        mask_next     = do_wmask ? cmd.wdata : mask_reg; // R02
        loop_next     = do_wloop ? cmd.wdata : loop_reg; // R01
        mask_pri_next = mask_next; // R02 R03
        mask_bak_next = mask_next[15:1]; // R03
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mask_reg     <= `IFW_MASK_RST;
            loop_reg     <= `IFW_LOOP_RST;
            mask_pri_reg <= `IFW_MASK_RST;
            mask_bak_reg <= 15'(`IFW_MASK_RST >> 1);
        end
        else
        begin
            mask_reg     <= mask_next;
            loop_reg     <= loop_next;
            mask_pri_reg <= mask_pri_next;
            mask_bak_reg <= mask_bak_next;
        end
    end

    // ------------------------------------------------------------------------
    // Dataway answer
    // ------------------------------------------------------------------------
    always_comb
    begin
        rsp_next.valid = cmd.valid;
        rsp_next.q     = known;
        rsp_next.x     = known;
        rsp_next.rdata = `IFW_ZERO16;
        if (do_read)
        begin
            case (cmd.sub)
                `IFW_SA_FAULT: rsp_next.rdata = fault_next; // R04 R06
                `IFW_SA_MASK:  rsp_next.rdata = mask_reg;
                `IFW_SA_LOOP:  rsp_next.rdata = loop_reg; // R01
                default:       rsp_next.rdata = `IFW_ZERO16;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rsp_reg <= '0;
        end
        else
        begin
            rsp_reg <= rsp_next;
        end
    end

    // ------------------------------------------------------------------------
    // Permission outputs
    // ------------------------------------------------------------------------
    always_comb
    begin
        // On a trip the permit and aux outputs freeze at the level seen then and the line is pulled low
        if (state_next == IFW_PERMIT)
        begin
            perm_next    = phase_next;
            // Line let go for a cycle on release so the relatch sees an outside short
            line_oe_next = ~phase_next & (state_reg == IFW_PERMIT); // R07
        end
        else
        begin
            perm_next    = perm_reg; // R12 R13
            line_oe_next = 1'b1; // R12
        end
        aux_next      = perm_next;
        trip_out_next = wd_trip; // R12
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            perm_reg     <= 1'b0;
            aux_reg      <= 1'b0;
            trip_out_reg <= 1'b0;
            line_oe_reg  <= 1'b0;
            line_o_reg   <= 1'b0;
        end
        else
        begin
            perm_reg     <= perm_next;
            aux_reg      <= aux_next;
            trip_out_reg <= trip_out_next;
            line_oe_reg  <= line_oe_next;
            line_o_reg   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Output ports
    // ------------------------------------------------------------------------
    assign rsp                     = rsp_reg;
    assign shutdown_interlock      = perm_reg;
    assign auxiliary_permit_output = aux_reg;
    assign timer_trip_output       = trip_out_reg;
    assign shared_line_o           = line_o_reg;
    assign shared_line_oe          = line_oe_reg;
    assign mask_pri                = mask_pri_reg;
    assign mask_bak                = mask_bak_reg;

endmodule : ifw_node

`default_nettype wire

// File: src/ifw_map.svh
// Offsets, encodings, reset values and timing counts of the interlock watchdog node
`ifndef IFW_MAP_SVH
`define IFW_MAP_SVH

// ----------------------------------------------------------------------------
// Dataway function codes and subaddresses
// ----------------------------------------------------------------------------
`define IFW_FN_READ         5'h00
`define IFW_FN_WRITE        5'h10
`define IFW_FN_RESET        5'h09
`define IFW_SA_FAULT        4'h0
`define IFW_SA_NOP          4'h0
`define IFW_SA_MASK         4'h1
`define IFW_SA_LOOP         4'h3

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define IFW_WD_BIT          15
`define IFW_LINE_BIT        0
`define IFW_CHAN_MSB        14
`define IFW_FAULT_RST       16'h0000
`define IFW_MASK_RST        16'h0000
`define IFW_LOOP_RST        16'h0000
`define IFW_ZERO16          16'h0000

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define IFW_CLK_HZ          125000000
`define IFW_PERMIT_HZ       5000000
`define IFW_DIV_CYCLES      (`IFW_CLK_HZ / `IFW_PERMIT_HZ)
`define IFW_DIV_HALF        (`IFW_DIV_CYCLES / 2)
`define IFW_WD_BASE_TICKS   32768
`define IFW_WD_CNT_W        31

`endif

// File: src/ifw_pkg.sv
// Types shared by the interlock watchdog node modules
package ifw_pkg;

    // ------------------------------------------------------------------------
    // Dataway command and answer
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [4:0]  func;
        logic [3:0]  sub;
        logic [15:0] wdata;
    } ifw_cmd_t;

    typedef struct packed {
        logic        valid;
        logic        q;
        logic        x;
        logic [15:0] rdata;
    } ifw_rsp_t;

    // ------------------------------------------------------------------------
    // Permission latch
    // ------------------------------------------------------------------------
    typedef enum logic [0:0] {
        IFW_PERMIT  = 1'b0,
        IFW_TRIPPED = 1'b1
    } ifw_state_t;

endpackage : ifw_pkg

// File: src/ifw_watchdog.sv
// Access watchdog counted on the 5 MHz permission tick
`timescale 1ns/100ps
`default_nettype none
`include "ifw_map.svh"

module ifw_watchdog #(
    parameter int unsigned BASE_TICKS = `IFW_WD_BASE_TICKS
) (
    input  wire logic       clk,     // System clock
    input  wire logic       sys_rst, // Synchronous reset
    input  wire logic       tick,    // One cycle per permission period
    input  wire logic       clear,   // Dataway access seen
    input  wire logic [3:0] sel,     // Timeout switch value
    output logic            trip     // Timeout reached
);

    logic [`IFW_WD_CNT_W-1:0] count_reg;
    logic [`IFW_WD_CNT_W-1:0] count_next;
    logic                     trip_reg;
    logic                     trip_next;
    logic [`IFW_WD_CNT_W-1:0] limit;
    logic                     hit;

    // Limit doubles per switch step; base count gives the shortest timeout
    function automatic logic [`IFW_WD_CNT_W-1:0] wd_limit(input logic [3:0] s);
        wd_limit = `IFW_WD_CNT_W'(BASE_TICKS) << s;
    endfunction : wd_limit

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    always_comb
    begin
        limit      = wd_limit(sel); // R09 R14
        hit        = tick && !trip_reg && (count_reg == limit - `IFW_WD_CNT_W'(1)); // R10
        count_next = count_reg;
        if (clear)
            count_next = '0; // R11
        else if (tick && !trip_reg)
            count_next = count_reg + `IFW_WD_CNT_W'(1); // R10
        // Set wins over a clear in the same cycle, so a trip is never lost
        trip_next  = hit | (trip_reg & ~clear); // R12
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            count_reg <= '0;
            trip_reg  <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            trip_reg  <= trip_next;
        end
    end

    assign trip = trip_reg;

endmodule : ifw_watchdog

`default_nettype wire

// File: test/ifw_node_monitor.sv
// Port-level assertions for the interlock node
`timescale 1ns/100ps
`default_nettype none
`include "ifw_map.svh"

module ifw_node_monitor #(
    parameter int unsigned WD_BASE_TICKS = 4
) (
    input wire logic              clk,                // System clock
    input wire logic              sys_rst,            // Synchronous reset
    input wire ifw_pkg::ifw_cmd_t cmd,                // Dataway command
    input wire ifw_pkg::ifw_rsp_t rsp,                // Dataway answer
    input wire logic [3:0]        timeout_sel,        // Watchdog switch
    input wire logic              shared_line_oe,     // Line pulled low
    input wire logic              shutdown_interlock, // Permission train
    input wire logic              timer_trip_output,  // Watchdog tripped
    input wire logic [15:0]       mask_pri,           // Mask primary
    input wire logic [15:1]       mask_bak            // Mask backup
);
    import ifw_pkg::*;

    logic [15:0] loop_reg, loop_next;
    logic [39:0] idle_reg, idle_next, span;
    logic        wr_mask, rd_loop;

    // Idle time is counted in system clocks, so the tick phase costs up to one period
    always_comb
    begin
        wr_mask   = cmd.valid && cmd.func == `IFW_FN_WRITE && cmd.sub == `IFW_SA_MASK;
        rd_loop   = cmd.valid && cmd.func == `IFW_FN_READ && cmd.sub == `IFW_SA_LOOP;
        loop_next = loop_reg;
        if (cmd.valid && cmd.func == `IFW_FN_WRITE && cmd.sub == `IFW_SA_LOOP)
            loop_next = cmd.wdata;
        idle_next = cmd.valid ? 40'h0 : idle_reg + 40'h1;
        span      = (40'(WD_BASE_TICKS) << timeout_sel) * 40'(`IFW_DIV_CYCLES);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            loop_reg <= `IFW_LOOP_RST;
            idle_reg <= 40'h0;
        end
        else
        begin
            loop_reg <= loop_next;
            idle_reg <= idle_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_rsp_follow: assert property (cmd.valid |=> rsp.valid)
        else $error("no answer one cycle after a command");
    chk_mask_write: assert property (wr_mask |=> mask_pri == $past(cmd.wdata))
        else $error("mask outputs differ from written word");
    chk_mask_hold: assert property (!wr_mask |=> $stable(mask_pri))
        else $error("mask outputs moved without a write");
    chk_mask_twin: assert property (mask_bak == mask_pri[15:1])
        else $error("backup mask differs from primary");
    chk_loop_read: assert property (rd_loop |=> rsp.rdata == loop_reg)
        else $error("loopback read differs from last write");
    chk_trip_pulls: assert property ($rose(timer_trip_output) |-> shared_line_oe)
        else $error("watchdog trip without removed permission");
    chk_trip_freeze: assert property (shared_line_oe && $past(shared_line_oe)
        |-> $stable(shutdown_interlock))
        else $error("permission train moved while latched");
    // A command on the very timeout edge may leave the trip set, so start from a shown trip
    chk_wd_clear: assert property (cmd.valid && timer_trip_output |-> ##2 !timer_trip_output)
        else $error("access did not clear the watchdog");
    chk_wd_late: assert property (idle_reg >= span + 40'h4 |-> timer_trip_output)
        else $error("watchdog did not trip in time");
    chk_wd_early: assert property (idle_reg >= 40'h2 && idle_reg + 40'h19 < span
        |-> !timer_trip_output)
        else $error("watchdog tripped too early");

endmodule : ifw_node_monitor

bind ifw_node ifw_node_monitor #(.WD_BASE_TICKS(WD_BASE_TICKS)) u_monitor (
    .clk, .sys_rst, .cmd, .rsp, .timeout_sel, .shared_line_oe,
    .shutdown_interlock, .timer_trip_output, .mask_pri, .mask_bak
);
`default_nettype wire

// File: test/ifw_ctrl_model.sv
// Crate controller model issuing dataway commands to the node
`timescale 1ns/100ps
`default_nettype none
`include "ifw_map.svh"

module ifw_ctrl_model (
    input  wire logic              clk, // System clock
    output var  ifw_pkg::ifw_cmd_t cmd, // Command to the node
    input  wire ifw_pkg::ifw_rsp_t rsp  // Answer from the node
);
    import ifw_pkg::*;

    initial cmd = '0;

    // Idle bus shows inverted fields so a stale word never looks live
    task automatic issue(input logic [4:0] f, input logic [3:0] a,
                         input logic [15:0] d, output ifw_rsp_t r);
        @(posedge clk);
        cmd <= '{valid: 1'b1, func: f, sub: a, wdata: d};
        @(posedge clk);
        cmd <= '{valid: 1'b0, func: ~f, sub: ~a, wdata: ~d};
        @(negedge clk);
        r = rsp;
    endtask : issue

endmodule : ifw_ctrl_model
`default_nettype wire

// File: test/ifw_node_bench.sv
// Self-checking bench for the interlock node with a controller model
`timescale 1ns/100ps
`default_nettype none
`include "ifw_map.svh"

module ifw_node_bench;
    import ifw_pkg::*;

    localparam int unsigned WDB = 4;

    typedef struct packed {
        logic [4:0]  f;
        logic [3:0]  a;
        logic [15:0] d;
        logic        q;
        logic [15:0] rd;
        logic [15:0] m;
    } ifw_row_t;

    // ----------------------------------------------------------------
    // Register rows: command, answer flag, read data, mask outputs
    // ----------------------------------------------------------------
    localparam ifw_row_t ROWS [11] = '{
        '{`IFW_FN_WRITE, `IFW_SA_LOOP, 16'h0000, 1'b1, 16'h0000, 16'h0000},
        '{`IFW_FN_READ,  `IFW_SA_LOOP, 16'ha5a5, 1'b1, 16'h0000, 16'h0000},
        '{`IFW_FN_WRITE, `IFW_SA_LOOP, 16'h0fff, 1'b1, 16'h0000, 16'h0000},
        '{`IFW_FN_READ,  `IFW_SA_LOOP, 16'h0000, 1'b1, 16'h0fff, 16'h0000},
        '{`IFW_FN_WRITE, `IFW_SA_MASK, 16'hffff, 1'b1, 16'h0000, 16'hffff},
        '{`IFW_FN_READ,  `IFW_SA_MASK, 16'h0000, 1'b1, 16'hffff, 16'hffff},
        '{`IFW_FN_WRITE, `IFW_SA_MASK, 16'h0fff, 1'b1, 16'h0000, 16'h0fff},
        '{`IFW_FN_WRITE, `IFW_SA_MASK, 16'h0000, 1'b1, 16'h0000, 16'h0000},
        '{`IFW_FN_READ,  4'h2,         16'h0000, 1'b0, 16'h0000, 16'h0000},
        '{5'h01,         `IFW_SA_NOP,  16'h0000, 1'b0, 16'h0000, 16'h0000},
        '{`IFW_FN_WRITE, `IFW_SA_NOP,  16'h1234, 1'b1, 16'h0000, 16'h0000}
    };

    logic        clk, sys_rst, ext_short, line_lvl, line_drv;
    logic [14:1] chan_permit;
    logic [3:0]  timeout_sel;
    ifw_cmd_t    cmd;
    ifw_rsp_t    rsp, r;
    logic        shared_line_oe, shutdown_interlock;
    logic        auxiliary_permit_output, timer_trip_output;
    logic [15:0] mask_pri;
    logic [15:1] mask_bak;
    int          n_errors = 0;
    int          checks_done = 0;
    int          highs, aux_highs, rel_highs, lim;

    // Open-drain line: low when the node or an outside short pulls it
    assign line_lvl = ~(shared_line_oe | ext_short);

    ifw_node #(.WD_BASE_TICKS(WDB)) DUT (
        .clk(clk), .sys_rst(sys_rst), .cmd(cmd), .rsp(rsp),
        .chan_permit(chan_permit), .timeout_sel(timeout_sel),
        .shared_line_i(line_lvl), .shared_line_o(line_drv), .shared_line_oe(shared_line_oe),
        .shutdown_interlock(shutdown_interlock),
        .auxiliary_permit_output(auxiliary_permit_output),
        .timer_trip_output(timer_trip_output), .mask_pri(mask_pri), .mask_bak(mask_bak)
    );

    ifw_ctrl_model ctrl (.clk(clk), .cmd(cmd), .rsp(rsp));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic reset_read(input logic [15:0] exp);
        ctrl.issue(`IFW_FN_RESET, `IFW_SA_NOP, 16'h0000, r);
        ctrl.issue(`IFW_FN_READ, `IFW_SA_FAULT, 16'h0000, r);
        check("fault register", exp, r.rdata);
    endtask : reset_read

    task automatic final_report;
        $display("Mismatches %0d, comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    initial
    begin
        sys_rst = 1'b1;
        ext_short = 1'b0;
        chan_permit = 14'h0000;
        timeout_sel = 4'h1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (ROWS[i])
        begin
            ctrl.issue(ROWS[i].f, ROWS[i].a, ROWS[i].d, r);
            check("answer valid", 16'h0001, 16'(r.valid));
            check("answer q", 16'(ROWS[i].q), 16'(r.q));
            check("answer x", 16'(ROWS[i].q), 16'(r.x));
            check("read data", ROWS[i].rd, r.rdata);
            check("mask primary", ROWS[i].m, mask_pri);
            check("mask backup", ROWS[i].m, {mask_bak, mask_pri[0]});
        end
        @(posedge clk);
        chan_permit <= 14'h2aaa;
        reset_read(16'h2aaa);
        @(posedge clk);
        chan_permit <= 14'h0000;
        reset_read(16'h7ffe);
        check("line pulled", 16'h0001, 16'(shared_line_oe));
        check("line drive low", 16'h0000, 16'(line_drv));
        @(posedge clk);
        ext_short <= 1'b1;
        reset_read(16'h7fff);
        @(posedge clk);
        ext_short <= 1'b0;
        ctrl.issue(`IFW_FN_WRITE, `IFW_SA_MASK, 16'hffff, r);
        ctrl.issue(`IFW_FN_READ, `IFW_SA_FAULT, 16'h0000, r);
        check("latched faults", 16'h7fff, r.rdata);
        ctrl.issue(`IFW_FN_RESET, `IFW_SA_NOP, 16'h0000, r);
        reset_read(16'h0000);
        highs = 0;
        aux_highs = 0;
        rel_highs = 0;
        repeat (60)
        begin
            @(negedge clk);
            highs += int'(shutdown_interlock);
            aux_highs += int'(auxiliary_permit_output);
            rel_highs += int'(!shared_line_oe);
        end
        // Once permitted the line carries the train, so it is let go about half the time
        check("line released", 16'h0001, 16'(rel_highs >= 24 && rel_highs <= 34));
        check("permit train", 16'h0001, 16'(highs >= 24 && highs <= 34));
        check("aux train", 16'h0001, 16'(aux_highs >= 24 && aux_highs <= 34));
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            timeout_sel <= 4'(s);
            ctrl.issue(`IFW_FN_RESET, `IFW_SA_NOP, 16'h0000, r);
            ctrl.issue(`IFW_FN_RESET, `IFW_SA_NOP, 16'h0000, r);
            lim = int'(WDB << s) * `IFW_DIV_CYCLES;
            repeat (lim - 29) @(negedge clk);
            check("early trip", 16'h0000, 16'(timer_trip_output));
            repeat (36) @(negedge clk);
            check("timeout trip", 16'h0001, 16'(timer_trip_output));
            check("trip pulls line", 16'h0001, 16'(shared_line_oe));
            ctrl.issue(`IFW_FN_READ, `IFW_SA_FAULT, 16'h0000, r);
            check("status read", 16'h0000, r.rdata);
            @(negedge clk);
            check("trip cleared", 16'h0000, 16'(timer_trip_output));
        end
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        ctrl.issue(`IFW_FN_READ, `IFW_SA_LOOP, 16'h0000, r);
        check("loopback after reset", `IFW_LOOP_RST, r.rdata);
        check("mask after reset", `IFW_MASK_RST, mask_pri);
        final_report();
    end

    // Whole run is under two thousand cycles; this cuts a hang short
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("ERROR run length expected under 20000 cycles seen timeout");
        final_report();
    end

endmodule : ifw_node_bench
`default_nettype wire
